//--- dv/spi_host_model.sv
// Serial host that programs and reads back the mode registers
`timescale 1ns/1ps
module spi_host_model (
	input  wire logic clk,
	output logic      cs_n,
	output logic      sck,
	output logic      sdi,
	input  wire logic sdo_line
);
	initial begin
		cs_n = 1'b1;
		sck  = 1'b0;
		sdi  = 1'b0;
	end

	// Clock held high six cycles and low seven, at least three times the sync depth of the pins
	task automatic xfer(input logic rw, input logic [6:0] addr, input logic [7:0] data,
		input int nbits, output logic [7:0] rd);
		logic [15:0] word;
		word = {rw, addr, data};
		rd = 8'h00;
		@(posedge clk) cs_n <= 1'b0;
		for (int i = 0; i < nbits; i++) begin
			@(posedge clk) sdi <= word[15 - i];
			repeat (5) @(posedge clk);
			if (i >= 8)
				rd[15 - i] = sdo_line;
			@(posedge clk) sck <= 1'b1;
			repeat (6) @(posedge clk);
			sck <= 1'b0;
		end
		repeat (6) @(posedge clk);
		cs_n <= 1'b1;
		// Released data line must not keep showing the last bit
		sdi <= ~sdi;
		repeat (8) @(posedge clk);
	endtask
endmodule // spi_host_model

//--- dv/tb_top.sv
// Self-checking bench for the mode control registers
`timescale 1ns/1ps
module tb_top;
	import adc_mode_pkg::*;
	logic        CLK, RST, STRAP;
	wire         cs_n, sck, sdi;
	logic        sdo_out, sdo_oe, dso, scr, sgn, slp, term, off, two, lok, pen;
	logic [3:0]  nap, ena, chp;
	logic [2:0]  csel, lsel;
	logic [7:0]  cur, rd;
	logic [4:0]  sbits;
	logic [13:0] tp;
	logic [5:0]  i;
	mode_reg_t   mreg [1:4];
	int          errors, samples_checked, cycles, seed;
	// External pull-up on the open-drain line
	wire         sdo_line = sdo_oe ? 1'b0 : 1'b1;

	quad_adc_mode_control_regs dut_u (.CLK(CLK), .RST(RST), .CS_N(cs_n), .SCK(sck), .SDI(sdi),
		.PROGRAM_MODE_STRAP(STRAP), .SDO_OUT(sdo_out), .SDO_OE(sdo_oe),
		.DUTY_STABILIZER_DISABLE(dso), .OUTPUT_SCRAMBLE_EN(scr), .SIGNED_FORMAT_SEL(sgn),
		.SLEEP_MODE(slp), .CH_NAP(nap), .CH_ENABLE(ena), .DRIVER_CURRENT_SEL(csel),
		.DRIVER_CURRENT(cur), .INTERNAL_TERM_EN(term), .OUTPUT_DISABLE(off),
		.LANE_SERIAL_SEL(lsel), .TWO_LANE(two), .SERIAL_BITS(sbits), .LANE_MODE_VALID(lok),
		.PATTERN_OUT_EN(pen), .CH_PATTERN(chp), .TEST_PATTERN(tp));

	spi_host_model host_u (.clk(CLK), .cs_n(cs_n), .sck(sck), .sdi(sdi), .sdo_line(sdo_line));

	always #20 CLK = ~CLK;

	task give_verdict;
		$display("Checks %0d, errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Run of about 70 frames at some 220 cycles each
	always @(posedge CLK) begin
		cycles++;
		if (cycles == 30000) begin
			errors++;
			$display("Error at %0t: run hung", $time);
			give_verdict();
		end
	end

	task chk(input logic ok, input string msg);
		samples_checked++;
		if (ok !== 1'b1) begin
			errors++;
			$display("Error at %0t: %s", $time, msg);
		end
	endtask

	task automatic check_all;
		logic [7:0] f, o, h, l;
		logic [3:0] e;
		int c, n;
		f = mreg[1];
		o = mreg[2];
		h = mreg[3];
		l = mreg[4];
		e = f[4] ? 4'h0 : ~f[3:0];
		case (o[7:5])
			3'h0: c = 70;
			3'h1: c = 80;
			3'h2: c = 90;
			3'h4: c = 60;
			3'h5: c = 50;
			3'h6: c = 42;
			3'h7: c = 35;
			default: c = 0;
		endcase
		if (o[4])
			c = c * 2;
		case (o[2:0])
			3'h0, 3'h7: n = 16;
			3'h1, 3'h5: n = 14;
			3'h2, 3'h6: n = 12;
			default: n = 0;
		endcase
		chk(dso === f[7], "stabilizer");
		chk(scr === f[6], "scramble");
		chk(sgn === f[5], "format");
		chk(slp === f[4], "sleep");
		chk(nap === (f[4] ? 4'h0 : f[3:0]), "nap");
		chk(ena === e, "enable");
		chk({csel, cur} === {o[7:5], 8'(c)}, "current");
		chk({term, off} === o[4:3], "term or off");
		chk({lsel, two, sbits, lok} === {o[2:0], o[2:0] < 3'h3, 5'(n), n != 0}, "lane");
		chk(pen === h[7], "pattern enable");
		chk(tp === {h[5:0], l}, "pattern");
		chk(chp === (h[7] ? e : 4'h0), "pattern channels");
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		host_u.xfer(1'b0, a, d, 16, rd);
		if (!STRAP && a >= 7'h01 && a <= 7'h04)
			mreg[a[2:0]] = (a == 7'h03) ? (d & 8'hbf) : d;
		check_all();
	endtask

	task automatic rdc(input logic [6:0] a);
		logic [7:0] e;
		e = (a >= 7'h01 && a <= 7'h04) ? mreg[a[2:0]] : 8'h00;
		host_u.xfer(1'b1, a, 8'($random(seed)), 16, rd);
		chk(rd === e && sdo_out === 1'b0, "readback");
		check_all();
	endtask

	initial begin
		CLK = 1'b0;
		RST = 1'b1;
		STRAP = 1'b0;
		seed = 49019;
		for (int k = 1; k <= 4; k++)
			mreg[k] = 8'h00;
		repeat (6) @(posedge CLK);
		RST <= 1'b0;
		repeat (2) @(posedge CLK);
		for (i = 1; i <= 4; i++)
			rdc(7'(i));
		for (i = 0; i < 8; i++) begin
			wr(7'h02, {i[2:0], 2'($random(seed)), i[2:0]});
			rdc(7'h02);
		end
		for (i = 0; i < 32; i++)
			wr(7'h01, {3'($random(seed)), i[4:0]});
		rdc(7'h01);
		// Some channels awake so the pattern channel map is not trivially zero
		wr(7'h01, {3'($random(seed)), 5'h0a});
		wr(7'h03, 8'hc0 | 8'($random(seed)));
		wr(7'h04, 8'($random(seed)));
		rdc(7'h03);
		rdc(7'h04);
		wr(7'h02, 8'h05);
		wr(7'h03, {2'b01, 6'($random(seed))});
		wr(7'h05, 8'hff);
		wr(7'h7f, 8'h55);
		rdc(7'h05);
		rdc(7'h00);
		// Frame cut short after ten bits must leave everything alone
		host_u.xfer(1'b0, 7'h02, 8'hff, 10, rd);
		check_all();
		STRAP <= 1'b1;
		repeat (4) @(posedge CLK);
		wr(7'h01, 8'h10);
		STRAP <= 1'b0;
		repeat (4) @(posedge CLK);
		wr(7'h01, 8'h0f);
		host_u.xfer(1'b0, 7'h00, 8'h80, 16, rd);
		for (int k = 1; k <= 4; k++)
			mreg[k] = 8'h00;
		chk(slp === 1'b1, "reset sleep");
		repeat (40) @(posedge CLK);
		check_all();
		rdc(7'h03);
		give_verdict();
	end
endmodule // tb_top

//--- rtl/adc_mode_params.svh
// Offsets, field positions, reset values and timing counts of the mode registers
`ifndef ADC_MODE_PARAMS_SVH
`define ADC_MODE_PARAMS_SVH

`define ADDR_SW_RESET      7'h00
`define ADDR_FORMAT_POWER  7'h01
`define ADDR_OUTPUT_MODE   7'h02
`define ADDR_PATTERN_HIGH  7'h03
`define ADDR_PATTERN_LOW   7'h04

`define REG_RESET_VALUE    8'h00

`define FP_DUTY_OFF        7
`define FP_SCRAMBLE        6
`define FP_SIGNED          5
`define FP_SLEEP           4
`define FP_NAP_HI          3
`define FP_NAP_LO          0

`define OM_CUR_HI          7
`define OM_CUR_LO          5
`define OM_TERM            4
`define OM_OFF             3
`define OM_LANE_HI         2
`define OM_LANE_LO         0

`define TP_ENABLE          7
`define TP_UNUSED          6
`define TP_HIGH_HI         5
`define SW_RESET_BIT       7

`define WORD_BITS          5'h10
`define ADDR_LAST_BIT      5'h07
`define DATA_FIRST_BIT     5'h08

// Driver current in steps of 0.05 mA
`define CUR_3P5            8'h46
`define CUR_4P0            8'h50
`define CUR_4P5            8'h5a
`define CUR_3P0            8'h3c
`define CUR_2P5            8'h32
`define CUR_2P1            8'h2a
`define CUR_1P75           8'h23

`define CLK_MHZ            25
`define SRST_SLEEP_NS      1000
`define SRST_SLEEP_CYCLES  ((`SRST_SLEEP_NS * `CLK_MHZ + 999) / 1000)

`endif

//--- rtl/adc_mode_pkg.sv
// Types shared by the mode register logic
package adc_mode_pkg;
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_SHIFT  = 2'b01,
		ST_COMMIT = 2'b11
	} frame_state_t;

	typedef logic [7:0] mode_reg_t;
endpackage

//--- rtl/mode_bus_if.sv
// Register contents toward the decoder and decoded controls back
`timescale 1ns/1ps
interface mode_bus_if;
	import adc_mode_pkg::*;
	mode_reg_t   fmt;
	mode_reg_t   om;
	mode_reg_t   tph;
	mode_reg_t   tpl;
	logic        force_sleep;
	logic        sleep;
	logic [3:0]  nap;
	logic [3:0]  enable;
	logic [7:0]  current;
	logic        two_lane;
	logic [4:0]  ser_bits;
	logic        lane_ok;
	logic [13:0] pattern;

	modport regs (output fmt, om, tph, tpl, force_sleep,
		input sleep, nap, enable, current, two_lane, ser_bits, lane_ok, pattern);
	modport dec (input fmt, om, tph, tpl, force_sleep,
		output sleep, nap, enable, current, two_lane, ser_bits, lane_ok, pattern);
endinterface

//--- rtl/mode_decode.sv
// Turns raw register contents into channel, driver, lane and pattern controls
`timescale 1ns/1ps
`include "adc_mode_params.svh"
module mode_decode
	import adc_mode_pkg::*;
(
	mode_bus_if.dec bus
);
	function automatic logic [7:0] base_current(input logic [2:0] sel);
		case (sel)
			3'h0:    base_current = `CUR_3P5;
			3'h1:    base_current = `CUR_4P0;
			3'h2:    base_current = `CUR_4P5;
			3'h4:    base_current = `CUR_3P0;
			3'h5:    base_current = `CUR_2P5;
			3'h6:    base_current = `CUR_2P1;
			3'h7:    base_current = `CUR_1P75;
			default: base_current = 8'h00;
		endcase
	endfunction

	logic [7:0] cur;

	always_comb begin
		bus.sleep  = bus.fmt[`FP_SLEEP] | bus.force_sleep;
		bus.nap    = bus.sleep ? 4'h0 : bus.fmt[`FP_NAP_HI:`FP_NAP_LO];
		bus.enable = bus.sleep ? 4'h0 : ~bus.fmt[`FP_NAP_HI:`FP_NAP_LO];
		cur = base_current(bus.om[`OM_CUR_HI:`OM_CUR_LO]);
		// Termination takes half the drive, so the driver doubles up
		bus.current = bus.om[`OM_TERM] ? {cur[6:0], 1'b0} : cur;
		bus.two_lane = 1'b0;
		bus.ser_bits = 5'h00;
		bus.lane_ok  = 1'b1;
		case (bus.om[`OM_LANE_HI:`OM_LANE_LO])
			3'h0: begin
				bus.two_lane = 1'b1;
				bus.ser_bits = 5'h10;
			end
			3'h1: begin
				bus.two_lane = 1'b1;
				bus.ser_bits = 5'h0e;
			end
			3'h2: begin
				bus.two_lane = 1'b1;
				bus.ser_bits = 5'h0c;
			end
			3'h5: bus.ser_bits = 5'h0e;
			3'h6: bus.ser_bits = 5'h0c;
			3'h7: bus.ser_bits = 5'h10;
			default: bus.lane_ok = 1'b0;
		endcase
		bus.pattern = {bus.tph[`TP_HIGH_HI:0], bus.tpl};
	end
endmodule // mode_decode

//--- rtl/pin_sync.sv
// Two-flop synchronisers for pins from outside the clock domain
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 4
) (
	input  wire logic         clk,
	input  wire logic [W-1:0] pin,
	output logic      [W-1:0] level
);
	logic [W-1:0] meta;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk) begin
				meta[i]  <= pin[i];
				level[i] <= meta[i];
			end
		end
	endgenerate
endmodule // pin_sync

//--- rtl/quad_adc_mode_control_regs.sv
// Serially programmed mode control registers of a four-channel converter
`timescale 1ns/1ps
`include "adc_mode_params.svh"

// Notes on behaviour
// - Format register bit 7 high turns the clock duty-cycle stabilizer off, low keeps it on.
// - Format register bit 6 turns the output data randomizer on when high.
// - Format register bit 5 selects offset binary when low and two's complement when high.
// - Format register bit 4 high puts the whole device to sleep with all channels off.
// - With bit 4 low, bits 0 to 3 nap channels 1 to 4, and all clear is normal running.
// - Any mix of nap bits is accepted, each channel napping on its own bit.
// - Output mode bits 7 to 5 pick the driver current from 1.75 mA to 4.5 mA, 011 unused.
// - Output mode bits 2 to 0 pick two lanes at 16, 14, 12 bits or one lane at 14, 12, 16 bits.
// - Pattern high bit 7 replaces output data with the programmed test pattern.
// - Pattern high bits 5 to 0 give pattern bits 13 down to 8.
// - Pattern low bits 7 to 0 give pattern bits 7 down to 0.
// - Pattern high bit 6 is ignored whatever is written to it.
// - A 16-bit word of read flag, 7 address bits and 8 data bits; a read leaves the register.
// - A software reset clears every mode register to zero and briefly forces sleep.
module quad_adc_mode_control_regs
	import adc_mode_pkg::*;
(
	input  wire logic  CLK,
	input  wire logic  RST,
	input  wire logic  CS_N,
	input  wire logic  SCK,
	input  wire logic  SDI,
	input  wire logic  PROGRAM_MODE_STRAP,
	output logic       SDO_OUT,
	output logic       SDO_OE,
	output logic       DUTY_STABILIZER_DISABLE,
	output logic       OUTPUT_SCRAMBLE_EN,
	output logic       SIGNED_FORMAT_SEL,
	output logic       SLEEP_MODE,
	output logic [3:0] CH_NAP,
	output logic [3:0] CH_ENABLE,
	output logic [2:0] DRIVER_CURRENT_SEL,
	output logic [7:0] DRIVER_CURRENT,
	output logic       INTERNAL_TERM_EN,
	output logic       OUTPUT_DISABLE,
	output logic [2:0] LANE_SERIAL_SEL,
	output logic       TWO_LANE,
	output logic [4:0] SERIAL_BITS,
	output logic       LANE_MODE_VALID,
	output logic       PATTERN_OUT_EN,
	output logic [3:0] CH_PATTERN,
	output logic [13:0] TEST_PATTERN
);
	localparam logic [7:0] SLEEP_CYCLES = 8'(`SRST_SLEEP_CYCLES);

	logic [3:0]   pins_s;
	logic         cs_n_s;
	logic         sck_s;
	logic         sdi_s;
	logic         strap_s;
	logic         sck_prev;
	logic         sck_rise;
	logic         sck_fall;

	frame_state_t state;
	frame_state_t next_state;
	logic [4:0]   bit_cnt;
	logic [4:0]   next_bit_cnt;
	logic [7:0]   shift;
	logic [7:0]   next_shift;
	logic         rd_flag;
	logic         next_rd_flag;
	logic [6:0]   addr_q;
	logic [6:0]   next_addr_q;
	logic [7:0]   rd_shift;
	logic [7:0]   next_rd_shift;
	logic         sdo_oe;
	logic         next_sdo_oe;

	mode_reg_t    fmt;
	mode_reg_t    next_fmt;
	mode_reg_t    om;
	mode_reg_t    next_om;
	mode_reg_t    tph;
	mode_reg_t    next_tph;
	mode_reg_t    tpl;
	mode_reg_t    next_tpl;
	logic [7:0]   srst_cnt;
	logic [7:0]   next_srst_cnt;

	mode_bus_if   bus ();

	pin_sync #(.W(4)) u_sync (
		.clk   (CLK),
		.pin   ({CS_N, SCK, SDI, PROGRAM_MODE_STRAP}),
		.level (pins_s)
	);

	assign cs_n_s  = pins_s[3];
	assign sck_s   = pins_s[2];
	assign sdi_s   = pins_s[1];
	assign strap_s = pins_s[0];
	assign sck_rise = sck_s & ~sck_prev;
	assign sck_fall = ~sck_s & sck_prev;

	// Reset register is write only, so it reads as zero like unmapped space
	function automatic logic [7:0] rd_value(input logic [6:0] a, input mode_reg_t f,
		input mode_reg_t o, input mode_reg_t h, input mode_reg_t l);
		case (a)
			`ADDR_FORMAT_POWER: rd_value = f;
			`ADDR_OUTPUT_MODE:  rd_value = o;
			`ADDR_PATTERN_HIGH: rd_value = h;
			`ADDR_PATTERN_LOW:  rd_value = l;
			default:            rd_value = 8'h00;
		endcase
	endfunction

	always_comb begin
		next_state    = state;
		next_bit_cnt  = bit_cnt;
		next_shift    = shift;
		next_rd_flag  = rd_flag;
		next_addr_q   = addr_q;
		next_rd_shift = rd_shift;
		next_sdo_oe   = sdo_oe;
		case (state)
			ST_IDLE: begin
				next_bit_cnt = 5'h00;
				next_sdo_oe  = 1'b0;
				// Parallel strap level hands the pins to pin programming
				if (!cs_n_s && !strap_s) begin
					next_state = ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				if (cs_n_s) begin
					next_sdo_oe = 1'b0;
					// A short frame is dropped rather than half applied
					next_state = (bit_cnt == `WORD_BITS) ? ST_COMMIT : ST_IDLE;
				end else begin
					if (sck_rise && bit_cnt < `WORD_BITS) begin
						next_shift   = {shift[6:0], sdi_s};
						next_bit_cnt = bit_cnt + 5'h01;
						if (bit_cnt == 5'h00) begin
							next_rd_flag = sdi_s;
						end
						if (bit_cnt == `ADDR_LAST_BIT) begin
							next_addr_q   = {shift[5:0], sdi_s};
							next_rd_shift = rd_value({shift[5:0], sdi_s}, fmt, om, tph, tpl);
						end
					end
					if (sck_fall && rd_flag && bit_cnt >= `DATA_FIRST_BIT
						&& bit_cnt < `WORD_BITS) begin
						// Open drain: enable pulls low for a zero bit
						next_sdo_oe   = ~rd_shift[7];
						next_rd_shift = {rd_shift[6:0], 1'b0};
					end
				end
			end
			ST_COMMIT: next_state = ST_IDLE;
			default:   next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			state    <= ST_IDLE;
			bit_cnt  <= 5'h00;
			shift    <= 8'h00;
			rd_flag  <= 1'b0;
			addr_q   <= 7'h00;
			rd_shift <= 8'h00;
			sdo_oe   <= 1'b0;
			sck_prev <= 1'b0;
		end else begin
			state    <= next_state;
			bit_cnt  <= next_bit_cnt;
			shift    <= next_shift;
			rd_flag  <= next_rd_flag;
			addr_q   <= next_addr_q;
			rd_shift <= next_rd_shift;
			sdo_oe   <= next_sdo_oe;
			sck_prev <= sck_s;
		end
	end

	always_comb begin
		next_fmt      = fmt;
		next_om       = om;
		next_tph      = tph;
		next_tpl      = tpl;
		next_srst_cnt = (srst_cnt != 8'h00) ? srst_cnt - 8'h01 : 8'h00;
		if (state == ST_COMMIT && !rd_flag) begin
			case (addr_q)
				`ADDR_SW_RESET: begin
					if (shift[`SW_RESET_BIT]) begin
						next_fmt      = `REG_RESET_VALUE;
						next_om       = `REG_RESET_VALUE;
						next_tph      = `REG_RESET_VALUE;
						next_tpl      = `REG_RESET_VALUE;
						next_srst_cnt = SLEEP_CYCLES;
					end
				end
				`ADDR_FORMAT_POWER: next_fmt = shift;
				`ADDR_OUTPUT_MODE:  next_om = shift;
				`ADDR_PATTERN_HIGH: next_tph = {shift[7], 1'b0, shift[5:0]};
				`ADDR_PATTERN_LOW:  next_tpl = shift;
				default: next_fmt = fmt;
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			fmt      <= `REG_RESET_VALUE;
			om       <= `REG_RESET_VALUE;
			tph      <= `REG_RESET_VALUE;
			tpl      <= `REG_RESET_VALUE;
			srst_cnt <= 8'h00;
		end else begin
			fmt      <= next_fmt;
			om       <= next_om;
			tph      <= next_tph;
			tpl      <= next_tpl;
			srst_cnt <= next_srst_cnt;
		end
	end

	assign bus.fmt         = fmt;
	assign bus.om          = om;
	assign bus.tph         = tph;
	assign bus.tpl         = tpl;
	assign bus.force_sleep = srst_cnt != 8'h00;

	mode_decode u_dec (
		.bus (bus.dec)
	);

	always_ff @(posedge CLK) begin
		if (RST) begin
			SDO_OUT                 <= 1'b0;
			SDO_OE                  <= 1'b0;
			DUTY_STABILIZER_DISABLE <= 1'b0;
			OUTPUT_SCRAMBLE_EN      <= 1'b0;
			SIGNED_FORMAT_SEL       <= 1'b0;
			SLEEP_MODE              <= 1'b0;
			CH_NAP                  <= 4'h0;
			CH_ENABLE               <= 4'h0;
			DRIVER_CURRENT_SEL      <= 3'h0;
			DRIVER_CURRENT          <= 8'h00;
			INTERNAL_TERM_EN        <= 1'b0;
			OUTPUT_DISABLE          <= 1'b0;
			LANE_SERIAL_SEL         <= 3'h0;
			TWO_LANE                <= 1'b0;
			SERIAL_BITS             <= 5'h00;
			LANE_MODE_VALID         <= 1'b0;
			PATTERN_OUT_EN          <= 1'b0;
			CH_PATTERN              <= 4'h0;
			TEST_PATTERN            <= 14'h0000;
		end else begin
			SDO_OUT                 <= 1'b0;
			SDO_OE                  <= sdo_oe;
			DUTY_STABILIZER_DISABLE <= fmt[`FP_DUTY_OFF];
			OUTPUT_SCRAMBLE_EN      <= fmt[`FP_SCRAMBLE];
			SIGNED_FORMAT_SEL       <= fmt[`FP_SIGNED];
			SLEEP_MODE              <= bus.sleep;
			CH_NAP                  <= bus.nap;
			CH_ENABLE               <= bus.enable;
			DRIVER_CURRENT_SEL      <= om[`OM_CUR_HI:`OM_CUR_LO];
			DRIVER_CURRENT          <= bus.current;
			INTERNAL_TERM_EN        <= om[`OM_TERM];
			OUTPUT_DISABLE          <= om[`OM_OFF];
			LANE_SERIAL_SEL         <= om[`OM_LANE_HI:`OM_LANE_LO];
			TWO_LANE                <= bus.two_lane;
			SERIAL_BITS             <= bus.ser_bits;
			LANE_MODE_VALID         <= bus.lane_ok;
			PATTERN_OUT_EN          <= tph[`TP_ENABLE];
			// Same pattern on every channel that is awake
			CH_PATTERN              <= tph[`TP_ENABLE] ? bus.enable : 4'h0;
			TEST_PATTERN            <= bus.pattern;
		end
	end

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);

	sequence s_write(logic [6:0] a);
		state == ST_COMMIT && !rd_flag && addr_q == a;
	endsequence

	sequence s_read_commit;
		state == ST_COMMIT && rd_flag;
	endsequence

	a_dcs_from_write: assert property (s_write(`ADDR_FORMAT_POWER) |=> ##1
		DUTY_STABILIZER_DISABLE == $past(shift[`FP_DUTY_OFF], 2))
		else $error("duty stabilizer bit not applied");
	a_scramble_sign: assert property (s_write(`ADDR_FORMAT_POWER) |=> ##1
		OUTPUT_SCRAMBLE_EN == $past(shift[6], 2) && SIGNED_FORMAT_SEL == $past(shift[5], 2))
		else $error("randomizer or coding bit not applied");
	a_sleep_all_off: assert property (SLEEP_MODE |-> CH_ENABLE == 4'h0 && CH_NAP == 4'h0)
		else $error("channel active during sleep");
	a_nap_per_chan: assert property (!fmt[`FP_SLEEP] && srst_cnt == 8'h00 |=>
		CH_NAP == $past(fmt[3:0]) && CH_ENABLE == ~$past(fmt[3:0]))
		else $error("nap bits not applied per channel");
	a_term_doubles: assert property (DRIVER_CURRENT_SEL == 3'h7 |->
		DRIVER_CURRENT == (INTERNAL_TERM_EN ? 8'h46 : 8'h23))
		else $error("driver current wrong for lowest setting");
	a_out_disable: assert property (s_write(`ADDR_OUTPUT_MODE) |=> ##1
		OUTPUT_DISABLE == $past(shift[3], 2))
		else $error("output disable not applied");
	a_lane_single: assert property (LANE_SERIAL_SEL == 3'h5 |->
		!TWO_LANE && SERIAL_BITS == 5'h0e && LANE_MODE_VALID)
		else $error("one lane 14 bit mode wrong");
	a_pattern_word: assert property (s_write(`ADDR_PATTERN_LOW) |=> ##1
		TEST_PATTERN[7:0] == $past(shift, 2) && PATTERN_OUT_EN == $past(tph[7], 2))
		else $error("pattern low byte not applied");
	a_unused_bit: assert property (tph[`TP_UNUSED] == 1'b0)
		else $error("pattern bit 6 stored");
	a_read_no_write: assert property (s_read_commit |=>
		fmt == $past(fmt) && om == $past(om) && tph == $past(tph) && tpl == $past(tpl))
		else $error("read changed a register");
	a_srst_clear: assert property (s_write(`ADDR_SW_RESET) ##0 shift[7] |=>
		fmt == 8'h00 && om == 8'h00 && tpl == 8'h00 ##1 SLEEP_MODE [*8])
		else $error("software reset did not clear and sleep");
endmodule // quad_adc_mode_control_regs
